// ==== ee_defines.svh ====
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH

// Select byte type identifiers.
`define EE_TYPE_ARRAY 4'hA
`define EE_TYPE_IDENT 4'hB

// Field positions inside the address and data bytes.
`define EE_ADDR_LOCK_BIT 7
`define EE_DATA_LOCK_BIT 1

// Sizes of the array and of one page.
`define EE_ARRAY_BYTES 256
`define EE_PAGE_BYTES 16

// Value sent when no byte is ready for transmission.
`define EE_IDLE_BYTE 8'hFF

// Internal write cycle time and the clock rate.
`define EE_TW_US 5000
`define EE_CLK_KHZ 25000
`define EE_TW_CYCLES ((`EE_TW_US * `EE_CLK_KHZ) / 1000)

`endif

// ==== ee_pkg.sv ====
package ee_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVSEL,
    ST_DSACK,
    ST_ADDR,
    ST_ADACK,
    ST_WDATA,
    ST_WDACK,
    ST_RDATA,
    ST_RACK,
    ST_BUSY
  } ee_state_t;

endpackage

// ==== ee_obuf.sv ====
`timescale 1ns/1ns
module ee_obuf (
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);

  logic [7:0] ent_r [0:1];
  logic [7:0] ent_nxt [0:1];
  logic wp_r;
  logic wp_nxt;
  logic rp_r;
  logic rp_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != 2'h2) && !flush;
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = ent_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready && !flush;

  always_comb begin
    ent_nxt[0] = ent_r[0];
    ent_nxt[1] = ent_r[1];
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (flush) begin
      wp_nxt = 1'b0;
      rp_nxt = 1'b0;
      cnt_nxt = 2'h0;
    end else begin
      if (push) begin
        ent_nxt[wp_r] = in_data;
        wp_nxt = ~wp_r;
      end
      if (pop) begin
        rp_nxt = ~rp_r;
      end
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ent_r[0] <= 8'h00;
      ent_r[1] <= 8'h00;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      ent_r[0] <= ent_nxt[0];
      ent_r[1] <= ent_nxt[1];
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// ==== ee_engine.sv ====
`timescale 1ns/1ns
`include "ee_defines.svh"
module ee_engine #(
  parameter int WR_CYCLES = `EE_TW_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic write_protect_input,
  input wire logic chip_select_bit2,
  input wire logic chip_select_bit1,
  input wire logic chip_select_bit0,
  input wire logic nv_erase,
  output logic write_busy,
  output logic ident_locked
);
  import ee_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus condition detection.

  logic [4:0] pin_m_r;
  logic [4:0] pin_s_r;
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_m_r <= 5'h1F;
      pin_s_r <= 5'h1F;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      pin_m_r <= {scl_i, sda_i, write_protect_input, chip_select_bit2,
                  chip_select_bit1 & chip_select_bit0 | 1'b0};
      pin_s_r <= pin_m_r;
      scl_d_r <= pin_s_r[4];
      sda_d_r <= pin_s_r[3];
    end
  end

  logic [1:0] cs_lo_m_r;
  logic [1:0] cs_lo_s_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_lo_m_r <= 2'h0;
      cs_lo_s_r <= 2'h0;
    end else begin
      cs_lo_m_r <= {chip_select_bit1, chip_select_bit0};
      cs_lo_s_r <= cs_lo_m_r;
    end
  end

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] cs_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_s = pin_s_r[4];
  assign sda_s = pin_s_r[3];
  assign wp_s = pin_s_r[2];
  assign cs_s = {pin_s_r[1], cs_lo_s_r};
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign bus_stop = scl_s && scl_d_r && !sda_d_r && sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Storage: array, identification page, lock flag and page buffer.

  logic [7:0] mem [0:`EE_ARRAY_BYTES-1];
  logic [7:0] id_mem [0:`EE_PAGE_BYTES-1];
  logic [7:0] pbuf [0:`EE_PAGE_BYTES-1];
  logic lock_r;

  function automatic logic [7:0] next_addr(input logic [7:0] a,
                                           input logic in_page);
    logic [7:0] r;
    r = a + 8'h01;
    if (in_page) begin
      r = {a[7:4], r[3:0]};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read-ahead buffer between the storage and the transmitter.

  logic flush;
  logic rd_active_r;
  logic [7:0] fetch_r;
  logic push_ready;
  logic [7:0] push_data;
  logic load;
  logic tx_valid;
  logic [7:0] tx_data;
  logic id_sel_r;

  assign push_data = id_sel_r ? id_mem[fetch_r[3:0]] : mem[fetch_r];

  ee_obuf u_obuf (
    .clk(clk),
    .nrst(nrst),
    .flush(flush),
    .in_valid(rd_active_r),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(tx_valid),
    .out_ready(load),
    .out_data(tx_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Instruction state machine.

  ee_state_t st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic oe_r, oe_nxt;
  logic rw_r, rw_nxt;
  logic id_sel_nxt;
  logic lock_mode_r, lock_mode_nxt;
  logic lock_req_r, lock_req_nxt;
  logic slot10_r, slot10_nxt;
  logic mack_r, mack_nxt;
  logic rd_active_nxt;
  logic [7:0] adr_r, adr_nxt;
  logic [7:0] fetch_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic [19:0] tw_r, tw_nxt;
  logic commit;
  logic store;
  logic ack_en;
  logic [7:0] tx_byte;

  assign tx_byte = tx_valid ? tx_data : `EE_IDLE_BYTE;
  assign ack_en = !wp_s && !(id_sel_r && lock_r);

  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    id_sel_nxt = id_sel_r;
    lock_mode_nxt = lock_mode_r;
    lock_req_nxt = lock_req_r;
    slot10_nxt = slot10_r;
    mack_nxt = mack_r;
    rd_active_nxt = rd_active_r;
    adr_nxt = adr_r;
    fetch_nxt = fetch_r;
    mask_nxt = mask_r;
    tw_nxt = tw_r;
    flush = 1'b0;
    load = 1'b0;
    commit = 1'b0;
    store = 1'b0;
    if (rd_active_r && push_ready) begin
      fetch_nxt = next_addr(fetch_r, id_sel_r);
    end
    case (st_r)
      ST_DEVSEL, ST_ADDR, ST_WDATA: begin
        if (scl_rise && cnt_r != 4'h8) begin
          sh_nxt = {sh_r[6:0], sda_s};
          cnt_nxt = cnt_r + 4'h1;
        end
        // The tenth slot closes on its falling clock edge, because a Stop
        // can only come after the rising edge that opens that slot.
        if (scl_fall) begin
          slot10_nxt = 1'b0;
        end
        if (scl_fall && cnt_r == 4'h8) begin
          cnt_nxt = 4'h0;
          if (st_r == ST_DEVSEL) begin
            if ((sh_r[7:4] == `EE_TYPE_ARRAY || sh_r[7:4] == `EE_TYPE_IDENT)
                && sh_r[3:1] == cs_s) begin
              st_nxt = ST_DSACK;
              oe_nxt = 1'b1;
              id_sel_nxt = (sh_r[7:4] == `EE_TYPE_IDENT);
              rw_nxt = sh_r[0];
              if (sh_r[0]) begin
                flush = 1'b1;
                rd_active_nxt = 1'b1;
                fetch_nxt = adr_r;
              end
            end else begin
              st_nxt = ST_IDLE;
            end
          end else if (st_r == ST_ADDR) begin
            st_nxt = ST_ADACK;
            oe_nxt = 1'b1;
            mask_nxt = 16'h0000;
            lock_mode_nxt = id_sel_r && sh_r[`EE_ADDR_LOCK_BIT];
            if (!id_sel_r) begin
              adr_nxt = sh_r;
            end else if (!sh_r[`EE_ADDR_LOCK_BIT]) begin
              adr_nxt = {4'h0, sh_r[3:0]};
            end
          end else begin
            st_nxt = ST_WDACK;
            oe_nxt = ack_en;
            if (ack_en && lock_mode_r) begin
              lock_req_nxt = lock_req_r | sh_r[`EE_DATA_LOCK_BIT];
            end else if (ack_en) begin
              store = 1'b1;
              mask_nxt = mask_r | (16'h0001 << adr_r[3:0]);
              adr_nxt = next_addr(adr_r, 1'b1);
            end
          end
        end
      end
      ST_DSACK, ST_ADACK, ST_WDACK: begin
        if (scl_fall) begin
          oe_nxt = 1'b0;
          cnt_nxt = 4'h0;
          if (st_r == ST_DSACK && rw_r) begin
            st_nxt = ST_RDATA;
            load = 1'b1;
            sh_nxt = tx_byte;
            oe_nxt = !tx_byte[7];
            adr_nxt = next_addr(adr_r, id_sel_r);
          end else if (st_r == ST_WDACK) begin
            st_nxt = ST_WDATA;
            slot10_nxt = 1'b1;
          end else if (st_r == ST_ADACK) begin
            st_nxt = ST_WDATA;
          end else begin
            st_nxt = ST_ADDR;
          end
        end
      end
      ST_RDATA: begin
        if (scl_fall) begin
          if (cnt_r == 4'h7) begin
            st_nxt = ST_RACK;
            oe_nxt = 1'b0;
          end else begin
            sh_nxt = {sh_r[6:0], 1'b1};
            oe_nxt = !sh_r[6];
            cnt_nxt = cnt_r + 4'h1;
          end
        end
      end
      ST_RACK: begin
        if (scl_rise) begin
          mack_nxt = !sda_s;
        end
        if (scl_fall) begin
          cnt_nxt = 4'h0;
          if (mack_r) begin
            st_nxt = ST_RDATA;
            load = 1'b1;
            sh_nxt = tx_byte;
            oe_nxt = !tx_byte[7];
            adr_nxt = next_addr(adr_r, id_sel_r);
          end else begin
            st_nxt = ST_IDLE;
            rd_active_nxt = 1'b0;
          end
        end
      end
      ST_BUSY: begin
        oe_nxt = 1'b0;
        if (tw_r == 20'h00000) begin
          commit = 1'b1;
          st_nxt = ST_IDLE;
        end else begin
          tw_nxt = tw_r - 20'h00001;
        end
      end
      default: begin
      end
    endcase
    if (st_r != ST_BUSY && bus_stop) begin
      oe_nxt = 1'b0;
      rd_active_nxt = 1'b0;
      if (st_r == ST_WDATA && slot10_r && (mask_r != 16'h0000 || lock_req_r))
      begin
        st_nxt = ST_BUSY;
        tw_nxt = 20'(WR_CYCLES - 1);
      end else begin
        st_nxt = ST_IDLE;
      end
    end else if (st_r != ST_BUSY && bus_start) begin
      st_nxt = ST_DEVSEL;
      oe_nxt = 1'b0;
      cnt_nxt = 4'h0;
      mask_nxt = 16'h0000;
      lock_req_nxt = 1'b0;
      slot10_nxt = 1'b0;
      rd_active_nxt = 1'b0;
      flush = 1'b1;
    end
    if (commit) begin
      mask_nxt = 16'h0000;
      lock_req_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      id_sel_r <= 1'b0;
      lock_mode_r <= 1'b0;
      lock_req_r <= 1'b0;
      slot10_r <= 1'b0;
      mack_r <= 1'b0;
      rd_active_r <= 1'b0;
      adr_r <= 8'h00;
      fetch_r <= 8'h00;
      mask_r <= 16'h0000;
      tw_r <= 20'h00000;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      oe_r <= oe_nxt;
      rw_r <= rw_nxt;
      id_sel_r <= id_sel_nxt;
      lock_mode_r <= lock_mode_nxt;
      lock_req_r <= lock_req_nxt;
      slot10_r <= slot10_nxt;
      mack_r <= mack_nxt;
      rd_active_r <= rd_active_nxt;
      adr_r <= adr_nxt;
      fetch_r <= fetch_nxt;
      mask_r <= mask_nxt;
      tw_r <= tw_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Non-volatile storage: no reset, so contents and lock survive it.

  always_ff @(posedge clk) begin
    if (store) begin
      pbuf[adr_r[3:0]] <= sh_r;
    end
    if (nv_erase) begin
      lock_r <= 1'b0;
    end else if (commit && lock_req_r) begin
      lock_r <= 1'b1;
    end
    for (int i = 0; i < `EE_PAGE_BYTES; i++) begin
      if (commit && mask_r[i]) begin
        if (id_sel_r) begin
          id_mem[i] <= pbuf[i];
        end else begin
          mem[{adr_r[7:4], 4'(i)}] <= pbuf[i];
        end
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_r;
  assign write_busy = (st_r == ST_BUSY);
  assign ident_locked = lock_r;

endmodule

// ==== ee_engine_sva.sv ====
`timescale 1ns/1ns
module ee_engine_chk #(
  parameter int WR_CYCLES = 50
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe,
  input wire logic write_protect_input,
  input wire logic nv_erase,
  input wire logic write_busy,
  input wire logic ident_locked
);
  int busy_cnt_r;
  int busy_cnt_nxt;

  always_comb begin
    busy_cnt_nxt = write_busy ? busy_cnt_r + 1 : 0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);

  a_busy_released: assert property (write_busy |-> !sda_oe)
    else $error("data line driven during write cycle");
  a_busy_length: assert property ($fell(write_busy) |-> busy_cnt_r == WR_CYCLES)
    else $error("write cycle length wrong");
  a_cycle_on_stop: assert property ($rose(write_busy) |-> scl_i && sda_i)
    else $error("write cycle started outside a stop");
  a_wp_blocks: assert property ($rose(write_busy) |-> !write_protect_input)
    else $error("write cycle while protected");
  a_lock_sticky: assert property (ident_locked && !nv_erase |=> ident_locked)
    else $error("lock flag cleared");
  a_lock_at_end: assert property ($rose(ident_locked) |-> $past(write_busy) || $past(write_busy, 2))
    else $error("lock set outside write cycle end");
  a_lock_quiet: assert property (write_busy |-> $stable(ident_locked))
    else $error("lock changed during write cycle");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data drive changed while clock high");

  c_write_cycle: cover property ($rose(write_busy));
  c_lock_set: cover property ($rose(ident_locked));
  c_ack_drive: cover property ($rose(sda_oe));
endmodule

bind ee_engine ee_engine_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .clk(clk),
  .nrst(nrst),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_oe(sda_oe),
  .write_protect_input(write_protect_input),
  .nv_erase(nv_erase),
  .write_busy(write_busy),
  .ident_locked(ident_locked)
);

// ==== ee_mst.sv ====
`timescale 1ns/1ns
module ee_mst (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Data moves an eighth of a period after the clock falls, sampled mid-high.
  task automatic bitx(input logic w, output logic r);
    #40 sda_low = !w;
    #120 scl = 1'b1;
    #80 r = sda;
    #80 scl = 1'b0;
  endtask

  task automatic start();
    #40 sda_low = 1'b0;
    #120 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask

  // The clock stands high after a stop until the next frame.
  task automatic stop();
    #40 sda_low = 1'b1;
    #120 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask

  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(!mack, a);
    ack = !a;
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wp = 1'b0;
  logic [2:0] cs = 3'h0;
  logic nv_erase = 1'b1;
  logic mlow, scl, sda_oe, sda_o, busy, locked, ack, lk;
  wire sda = !(mlow || (sda_oe && !sda_o));
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] mem [256];
  logic [7:0] idp [16];
  logic [7:0] ptr, q;

  always #20 clk = ~clk;

  ee_engine #(.WR_CYCLES(50)) dut (.clk(clk), .nrst(nrst), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .write_protect_input(wp),
    .chip_select_bit2(cs[2]), .chip_select_bit1(cs[1]),
    .chip_select_bit0(cs[0]), .nv_erase(nv_erase), .write_busy(busy),
    .ident_locked(locked));
  ee_mst m (.scl(scl), .sda_low(mlow), .sda(sda));

  ////////////////////////////////////////
  task print_verdict();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task hdr(input logic [3:0] ty, input logic [7:0] a);
    m.start();
    m.xfer({ty, cs, 1'b0}, 1'b0, q, ack);
    chk({7'h0, ack}, 8'h01);
    m.xfer(a, 1'b0, q, ack);
    chk({7'h0, ack}, 8'h01);
  endtask

  task idle_chk();
    repeat (8) @(negedge clk);
    chk({7'h0, busy}, 8'h00);
  endtask

  task poll();
    int n;
    n = 0;
    ack = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h0, busy}, 8'h01);
    while (!ack && n < 40) begin
      m.start();
      m.xfer({4'hA, cs, 1'b0}, 1'b0, q, ack);
      n++;
    end
    m.stop();
    chk({7'h0, n >= 2 && ack}, 8'h01);
  endtask

  task pwrite(input logic [3:0] ty, input logic [7:0] a, input int n);
    logic [7:0] d;
    logic ok;
    ok = !wp && !(ty == 4'hB && lk);
    hdr(ty, a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      m.xfer(d, 1'b0, q, ack);
      chk({7'h0, ack}, {7'h0, ok});
      if (ok && ty == 4'hA) mem[{a[7:4], 4'(a[3:0] + i)}] = d;
      if (ok && ty == 4'hB) idp[4'(a[3:0] + i)] = d;
    end
    if (ok && ty == 4'hA) ptr = {a[7:4], 4'(a[3:0] + n)};
    m.stop();
  endtask

  task rd(input logic [3:0] ty, input logic [7:0] a, input int n,
          input logic rnd);
    if (rnd) begin
      hdr(ty, a);
      ptr = (ty == 4'hA) ? a : {4'h0, a[3:0]};
    end
    m.start();
    m.xfer({ty, cs, 1'b1}, 1'b0, q, ack);
    chk({7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hFF, i < n - 1, q, ack);
      chk(q, ty == 4'hA ? mem[ptr] : idp[ptr[3:0]]);
      ptr = (ty == 4'hA) ? ptr + 8'h01 : {4'h0, ptr[3:0] + 4'h1};
    end
    m.stop();
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    lk = 1'b0;
    void'($urandom(32'h2224));
    cs = 3'($urandom);
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    nv_erase = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      m.start();
      m.xfer({i < 3 ? {2'(i), 2'b01} : 4'hA, i < 3 ? cs : ~cs, 1'b0},
             1'b0, q, ack);
      chk({7'h0, ack}, 8'h00);
      m.stop();
    end
    pwrite(4'hA, 8'hF0 | 8'($urandom % 16), 17);
    poll();
    pwrite(4'hA, 8'h01, 16);
    poll();
    rd(4'hA, 8'h00, 1, 1'b0);
    rd(4'hA, 8'hF8, 16, 1'b1);
    wp = 1'b1;
    pwrite(4'hA, 8'h03, 1);
    idle_chk();
    rd(4'hA, 8'h03, 1, 1'b1);
    wp = 1'b0;
    hdr(4'hA, 8'h20);
    m.stop();
    idle_chk();
    pwrite(4'hB, 8'h7E, 2);
    poll();
    rd(4'hB, 8'h0E, 2, 1'b1);
    hdr(4'hB, 8'h05);
    m.xfer(8'h5A, 1'b0, q, ack);
    chk({7'h0, ack}, 8'h01);
    m.start();
    m.stop();
    idle_chk();
    hdr(4'hB, 8'h80 | 8'($urandom % 128));
    m.xfer(8'h02 | 8'($urandom), 1'b0, q, ack);
    chk({7'h0, ack}, 8'h01);
    m.stop();
    poll();
    lk = 1'b1;
    chk({7'h0, locked}, 8'h01);
    pwrite(4'hB, 8'h02, 1);
    rd(4'hB, 8'h0E, 2, 1'b1);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chk({7'h0, locked}, 8'h01);
    print_verdict();
  end
endmodule
